// ### logic/esn_pkg.sv
// types of the event status information encoder
// assumes: esn_regs.svh is reachable on the include path
package esn_pkg;
`include "esn_regs.svh"

  typedef enum logic [1:0] {
    PM_NONE = 2'h0,
    PM_DONE = 2'h1,
    PM_FAIL = 2'h2
  } pm_kind_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h1,
    PWR_IDLE = 2'h2,
    PWR_STANDBY = 2'h3
  } pwr_state_t;

  typedef enum logic [1:0] {
    MED_NONE = 2'h0,
    MED_EJECT = 2'h1,
    MED_NEW = 2'h2,
    MED_REMOVED = 2'h3
  } media_kind_t;

  typedef enum logic [1:0] {
    BSY_READY = 2'h0,
    BSY_WAKE = 2'h1,
    BSY_EARLIER = 2'h2,
    BSY_DEFERRED = 2'h3
  } busy_reason_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } fsm_t;

  typedef struct packed {
    pm_kind_t kind;
    pwr_state_t state;
  } pm_rec_t;

  typedef struct packed {
    media_kind_t kind;
    logic door_open;
    logic present;
    logic [7:0] start_slot;
    logic [7:0] end_slot;
  } media_rec_t;

  typedef struct packed {
    logic timeout;
    busy_reason_t reason;
    logic [15:0] time_left;
  } busy_rec_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] sense_key;
    logic [7:0] sense_code;
    logic [7:0] qualifier;
    logic [3:0][7:0] info;
  } report_t;
endpackage

// ### logic/esn_regs.svh
// constants of the event status information encoder
// assumes: included by bare name from the package and the design files
`ifndef ESN_REGS_SVH
`define ESN_REGS_SVH

// report framing
`define ESN_STATUS_CHECK 8'h02
`define ESN_KEY_UNIT_ATTN 8'h06
`define ESN_CODE_EVENT 8'h7F
`define ESN_QUAL_POWER 8'h02
`define ESN_QUAL_MEDIA 8'h04
`define ESN_QUAL_BUSY 8'h06
`define ESN_RESERVED_BYTE 8'h00

// power management event and state codes
`define ESN_PM_EV_NONE 8'h00
`define ESN_PM_EV_DONE 8'h01
`define ESN_PM_EV_FAIL 8'h02
`define ESN_PWR_ACTIVE 8'h01
`define ESN_PWR_IDLE 8'h02
`define ESN_PWR_STANDBY 8'h03

// media event codes and status bit positions
`define ESN_MED_EV_NONE 8'h00
`define ESN_MED_EV_EJECT 8'h01
`define ESN_MED_EV_NEW 8'h02
`define ESN_MED_EV_REMOVED 8'h03
`define ESN_MED_DOOR_BIT 0
`define ESN_MED_PRESENT_BIT 1

// device busy event and status codes
`define ESN_BSY_EV_NONE 8'h00
`define ESN_BSY_EV_TIMEOUT 8'h01
`define ESN_BSY_READY 8'h00
`define ESN_BSY_WAKE 8'h01
`define ESN_BSY_EARLIER 8'h02
`define ESN_BSY_DEFERRED 8'h03

// timing: busy time unit and clock period
`define ESN_TIME_UNIT_MS 100
`define ESN_CLK_PERIOD_NS 100
`define ESN_TICK_CYCLES (`ESN_TIME_UNIT_MS * 1000000 / `ESN_CLK_PERIOD_NS)

// reset values
`define ESN_TIME_RESET 16'h0000
`define ESN_TICK_RESET 20'h0_0000

`endif

// ### logic/esn_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes: inputs are asynchronous levels, core_clk domain on the output
`timescale 1ns/1ps
module esn_sync #(
  parameter int W = 2
) (
  input wire logic core_clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [W-1:0] d, // asynchronous levels
  output logic [W-1:0] q // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_st_t;

  sync_st_t st;
  sync_st_t next_st;

  // first stage feeds only the second stage
  always_comb begin
    next_st.meta = d;
    next_st.stable = st.meta;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.stable;
endmodule // esn_sync

// ### logic/event_status_info_encoder.sv
// event status report builder: frames unsolicited status for three classes
// assumes: request strobes and enable come from logic on core_clk;
// door and media sense arrive as raw pins
`timescale 1ns/1ps
`include "esn_regs.svh"
module event_status_info_encoder #(
  parameter int TICK_CYCLES = `ESN_TICK_CYCLES
) (
  input wire logic core_clk, // 10 MHz system clock
  input wire logic rst, // async reset, active high
  input wire logic unsol_enable, // initiator enabled unsolicited status
  input wire logic multi_slot, // device has several slots
  input wire logic sense_when_open, // media sensed with door open
  input wire logic pm_req, // power event strobe
  input wire esn_pkg::pm_kind_t pm_kind, // power event kind
  input wire esn_pkg::pwr_state_t pm_state, // power state in force
  input wire logic media_req, // media event strobe
  input wire esn_pkg::media_kind_t media_kind, // media event kind
  input wire logic [7:0] start_slot, // first slot concerned
  input wire logic [7:0] end_slot, // last slot concerned
  input wire logic door_open_pin, // raw door or tray open level
  input wire logic media_present_pin, // raw media present level
  input wire logic busy_load, // load the busy time estimate
  input wire logic [15:0] busy_time, // estimate, 100 ms units
  input wire logic busy_req, // busy event strobe
  input wire logic busy_timeout, // busy event is a time-out
  input wire esn_pkg::busy_reason_t busy_reason, // why busy
  output logic rpt_valid, // report ready for transport
  input wire logic rpt_ready, // transport takes the report
  output esn_pkg::report_t rpt, // framed report
  output logic [2:0] pending, // {busy, media, power} waiting
  output logic [15:0] busy_remaining // live time estimate
);
  localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

  typedef struct packed {
    esn_pkg::fsm_t fsm;
    logic pm_pend;
    logic media_pend;
    logic busy_pend;
    esn_pkg::pm_rec_t pm;
    esn_pkg::media_rec_t media;
    esn_pkg::busy_rec_t busy;
    esn_pkg::report_t rpt;
    logic [19:0] tick;
    logic [15:0] remain;
  } enc_st_t;

  enc_st_t st;
  enc_st_t next_st;
  logic [1:0] pins;

  // door and media sense are raw pins: two flops before any use
  esn_sync #(
    .W(2)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d({media_present_pin, door_open_pin}),
    .q(pins)
  );

  function automatic logic [7:0] pm_event_byte(esn_pkg::pm_kind_t k);
    case (k)
      esn_pkg::PM_DONE: pm_event_byte = `ESN_PM_EV_DONE;
      esn_pkg::PM_FAIL: pm_event_byte = `ESN_PM_EV_FAIL;
      esn_pkg::PM_NONE: pm_event_byte = `ESN_PM_EV_NONE;
      default: pm_event_byte = `ESN_PM_EV_NONE;
    endcase
  endfunction

  function automatic logic [7:0] pwr_byte(esn_pkg::pwr_state_t s);
    case (s)
      esn_pkg::PWR_IDLE: pwr_byte = `ESN_PWR_IDLE;
      esn_pkg::PWR_STANDBY: pwr_byte = `ESN_PWR_STANDBY;
      esn_pkg::PWR_ACTIVE: pwr_byte = `ESN_PWR_ACTIVE;
      default: pwr_byte = `ESN_PWR_ACTIVE;
    endcase
  endfunction

  function automatic logic [7:0] med_event_byte(esn_pkg::media_kind_t k);
    case (k)
      esn_pkg::MED_EJECT: med_event_byte = `ESN_MED_EV_EJECT;
      esn_pkg::MED_NEW: med_event_byte = `ESN_MED_EV_NEW;
      esn_pkg::MED_REMOVED: med_event_byte = `ESN_MED_EV_REMOVED;
      esn_pkg::MED_NONE: med_event_byte = `ESN_MED_EV_NONE;
      default: med_event_byte = `ESN_MED_EV_NONE;
    endcase
  endfunction

  function automatic logic [7:0] busy_byte(esn_pkg::busy_reason_t r);
    case (r)
      esn_pkg::BSY_WAKE: busy_byte = `ESN_BSY_WAKE;
      esn_pkg::BSY_EARLIER: busy_byte = `ESN_BSY_EARLIER;
      esn_pkg::BSY_DEFERRED: busy_byte = `ESN_BSY_DEFERRED;
      esn_pkg::BSY_READY: busy_byte = `ESN_BSY_READY;
      default: busy_byte = `ESN_BSY_READY;
    endcase
  endfunction

  logic pm_take;
  logic media_take;
  logic busy_take;
  logic launch;

  logic door_sync;
  logic present_sync;
  logic present_eff;
  logic [7:0] med_status;

  logic counting;
  logic tick_wrap;

  logic [3:0][7:0] pm_info;
  logic [3:0][7:0] med_info;
  logic [3:0][7:0] bsy_info;
  esn_pkg::pm_rec_t pm_cap;
  esn_pkg::media_rec_t media_cap;
  esn_pkg::busy_rec_t busy_cap;
  esn_pkg::report_t frame;

  // requests only count while enabled: nothing queues up for later
  assign pm_take = pm_req & unsol_enable;
  assign media_take = media_req & unsol_enable;
  assign busy_take = busy_req & unsol_enable;

  // pin levels after the two-flop synchroniser
  assign door_sync = pins[0];
  assign present_sync = pins[1];

  // door and presence are sampled when the media event is taken
  assign present_eff = present_sync & (sense_when_open | ~door_sync);

  always_comb begin
    med_status = `ESN_RESERVED_BYTE;
    med_status[`ESN_MED_DOOR_BIT] = st.media.door_open;
    med_status[`ESN_MED_PRESENT_BIT] = st.media.present;
  end

  // each class fills all four information bytes, reserved ones with zero
  always_comb begin
    pm_info[0] = pm_event_byte(st.pm.kind);
    pm_info[1] = pwr_byte(st.pm.state);
    pm_info[2] = `ESN_RESERVED_BYTE;
    pm_info[3] = `ESN_RESERVED_BYTE;
  end

  // door and presence bits were frozen when the event was taken
  always_comb begin
    med_info[0] = med_event_byte(st.media.kind);
    med_info[1] = med_status;
    med_info[2] = st.media.start_slot;
    med_info[3] = st.media.end_slot;
  end

  // time estimate goes out most significant byte first
  always_comb begin
    bsy_info[0] = st.busy.timeout ? `ESN_BSY_EV_TIMEOUT
                                  : `ESN_BSY_EV_NONE;
    bsy_info[1] = busy_byte(st.busy.reason);
    bsy_info[2] = st.busy.time_left[15:8];
    bsy_info[3] = st.busy.time_left[7:0];
  end

  // fixed priority power, media, busy; one frame built per launch
  always_comb begin
    frame.status = `ESN_STATUS_CHECK;
    frame.sense_key = `ESN_KEY_UNIT_ATTN;
    frame.sense_code = `ESN_CODE_EVENT;
    if (st.pm_pend) begin
      frame.qualifier = `ESN_QUAL_POWER;
      frame.info = pm_info;
    end else if (st.media_pend) begin
      frame.qualifier = `ESN_QUAL_MEDIA;
      frame.info = med_info;
    end else begin
      frame.qualifier = `ESN_QUAL_BUSY;
      frame.info = bsy_info;
    end
  end

  // records as they would be captured in this cycle
  always_comb begin
    pm_cap.kind = pm_kind;
    pm_cap.state = pm_state;
  end

  always_comb begin
    media_cap.kind = media_kind;
    media_cap.door_open = door_sync;
    media_cap.present = present_eff;
    // single-slot devices must not leak slot numbers into reserved bytes
    media_cap.start_slot = multi_slot ? start_slot
                                      : `ESN_RESERVED_BYTE;
    media_cap.end_slot = multi_slot ? end_slot
                                    : `ESN_RESERVED_BYTE;
  end

  always_comb begin
    busy_cap.timeout = busy_timeout;
    busy_cap.reason = busy_reason;
    // a load in the same cycle is reported rather than the stale estimate
    busy_cap.time_left = busy_load ? busy_time : st.remain;
  end

  assign launch = (st.fsm == esn_pkg::ST_IDLE) & unsol_enable &
                  (st.pm_pend | st.media_pend | st.busy_pend);

  // the estimate stops at zero rather than wrapping to the maximum
  assign counting = (st.remain != `ESN_TIME_RESET);
  assign tick_wrap = (st.tick == TICK_LAST);

  always_comb begin
    next_st = st;

    // time estimate counts down once per 100 ms
    if (busy_load) begin
      next_st.remain = busy_time;
      next_st.tick = `ESN_TICK_RESET;
    end else if (counting) begin
      if (tick_wrap) begin
        next_st.tick = `ESN_TICK_RESET;
        next_st.remain = st.remain - 16'h0001;
      end else begin
        next_st.tick = st.tick + 20'h0_0001;
      end
    end

    case (st.fsm)
      esn_pkg::ST_IDLE: begin
        if (launch) begin
          next_st.rpt = frame;
          next_st.fsm = esn_pkg::ST_SEND;
          if (st.pm_pend) begin
            next_st.pm_pend = 1'b0;
          end else if (st.media_pend) begin
            next_st.media_pend = 1'b0;
          end else begin
            next_st.busy_pend = 1'b0;
          end
        end
      end
      esn_pkg::ST_SEND: begin
        // a frame once offered is held until taken
        if (rpt_ready) begin
          next_st.fsm = esn_pkg::ST_IDLE;
        end
      end
      default: begin
        next_st.fsm = esn_pkg::ST_IDLE;
      end
    endcase

    // disabling drops whatever has not yet been framed
    if (!unsol_enable) begin
      next_st.pm_pend = 1'b0;
      next_st.media_pend = 1'b0;
      next_st.busy_pend = 1'b0;
    end

    // a new event wins over the clear in the same cycle
    if (pm_take) begin
      next_st.pm_pend = 1'b1;
      next_st.pm = pm_cap;
    end
    if (media_take) begin
      next_st.media_pend = 1'b1;
      next_st.media = media_cap;
    end
    if (busy_take) begin
      next_st.busy_pend = 1'b1;
      next_st.busy = busy_cap;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // valid stays high until the transport takes the frame
  assign rpt_valid = (st.fsm == esn_pkg::ST_SEND);
  assign rpt = st.rpt;
  assign pending = {st.busy_pend, st.media_pend, st.pm_pend};
  assign busy_remaining = st.remain;
endmodule // event_status_info_encoder

// ### tb/esn_assertions.sv
// checker for the event status report builder
// assumes: bound to the encoder, sees its ports only
`timescale 1ns/1ps
module esn_checker #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic unsol_enable, // enable
  input wire logic multi_slot, // slots
  input wire logic pm_req, // power strobe
  input wire logic busy_load, // load
  input wire logic [15:0] busy_time, // estimate
  input wire logic rpt_valid, // offered
  input wire logic rpt_ready, // taken
  input wire esn_pkg::report_t rpt, // report
  input wire logic [2:0] pending, // waiting
  input wire logic [15:0] busy_remaining // live
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic [7:0] q;
  logic [31:0] inf;
  assign q = rpt.qualifier;
  assign inf = rpt.info;
  a_frame_fixed: assert property (
    rpt_valid |-> rpt[63:40] == 24'h02_067F) else $error("bad frame");
  a_class_code: assert property (
    rpt_valid |-> q inside {8'h02, 8'h04, 8'h06}) else $error("bad class");
  a_power_bytes: assert property (
    rpt_valid && q == 8'h02 |-> inf[7:0] < 8'h03 && inf[15:8] != 8'h00
    && inf[15:8] < 8'h04 && inf[31:16] == 16'h0000) else $error("bad power");
  a_single_slot: assert property (
    rpt_valid && q == 8'h04 && !multi_slot |-> inf[31:16] == 16'h0000)
    else $error("bad slots");
  a_busy_codes: assert property (
    rpt_valid && q == 8'h06 |-> inf[7:0] < 8'h02 && inf[15:8] < 8'h04)
    else $error("bad busy");
  a_enable_gate: assert property (
    !unsol_enable |=> pending == 3'h0) else $error("pending kept");
  a_power_taken: assert property (
    pm_req && unsol_enable |=> pending[0]) else $error("power lost");
  a_offer_holds: assert property (
    rpt_valid && !rpt_ready |=> rpt_valid && $stable(rpt))
    else $error("offer dropped");
  a_time_load: assert property (
    busy_load |=> busy_remaining == $past(busy_time)) else $error("bad load");
  a_time_step: assert property (
    !$past(busy_load) && $changed(busy_remaining) |->
    busy_remaining == $past(busy_remaining) - 16'h0001)
    else $error("bad step");
  c_power: cover property (rpt_valid && rpt_ready && q == 8'h02);
  c_media: cover property (rpt_valid && rpt_ready && q == 8'h04);
  c_busy: cover property (rpt_valid && rpt_ready && q == 8'h06);
endmodule // esn_checker

bind event_status_info_encoder esn_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .core_clk, .rst, .unsol_enable, .multi_slot, .pm_req, .busy_load,
  .busy_time, .rpt_valid, .rpt_ready, .rpt, .pending, .busy_remaining
);

// ### tb/esn_host.sv
// initiator model: takes framed reports, holding off a set number of cycles
// assumes: core_clk domain, registered valid and report from the encoder
`timescale 1ns/1ps
module esn_host (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic rpt_valid, // offered
  input wire esn_pkg::report_t rpt, // report
  input wire logic [3:0] stall, // hold-off cycles
  output logic rpt_ready, // taken
  output esn_pkg::report_t got, // last taken
  output logic [7:0] got_n // number taken
);
  logic [3:0] wait_n;
  // ready only while valid stands, so no stale acceptance
  assign rpt_ready = rpt_valid && wait_n >= stall;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_n <= 4'h0;
      got <= '0;
      got_n <= 8'h00;
    end else if (rpt_ready) begin
      wait_n <= 4'h0;
      got <= rpt;
      got_n <= got_n + 8'h01;
    end else if (rpt_valid) begin
      wait_n <= wait_n + 4'h1;
    end
  end
endmodule // esn_host

// ### tb/test_event_status_info_encoder.sv
// self-checking bench for the event status report builder
// assumes: package, design, host model and checker compiled before it
`timescale 1ns/1ps
module test_event_status_info_encoder;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic unsol_enable = 1'b1;
  logic multi_slot = 1'b0;
  logic sense_when_open = 1'b0;
  logic pm_req = 1'b0;
  esn_pkg::pm_kind_t pm_kind = esn_pkg::PM_NONE;
  esn_pkg::pwr_state_t pm_state = esn_pkg::PWR_ACTIVE;
  logic media_req = 1'b0;
  esn_pkg::media_kind_t media_kind = esn_pkg::MED_NONE;
  logic [7:0] start_slot = 8'h00;
  logic [7:0] end_slot = 8'h00;
  logic door_open_pin = 1'b0;
  logic media_present_pin = 1'b0;
  logic busy_load = 1'b0;
  logic [15:0] busy_time = 16'h0000;
  logic busy_req = 1'b0;
  logic busy_timeout = 1'b0;
  esn_pkg::busy_reason_t busy_reason = esn_pkg::BSY_READY;
  logic rpt_valid;
  logic rpt_ready;
  esn_pkg::report_t rpt;
  logic [2:0] pending;
  logic [15:0] busy_remaining;
  logic [3:0] stall = 4'h0;
  esn_pkg::report_t got;
  logic [7:0] got_n;
  int bad_count = 0;
  int n_tests = 0;

  always #50 core_clk = ~core_clk;

  // short tick so the countdown is seen within a few dozen cycles
  event_status_info_encoder #(.TICK_CYCLES(4)) DUT (
    .core_clk, .rst, .unsol_enable, .multi_slot, .sense_when_open, .pm_req,
    .pm_kind, .pm_state, .media_req, .media_kind, .start_slot, .end_slot,
    .door_open_pin, .media_present_pin, .busy_load, .busy_time, .busy_req,
    .busy_timeout, .busy_reason, .rpt_valid, .rpt_ready, .rpt, .pending,
    .busy_remaining
  );
  esn_host far (
    .core_clk, .rst, .rpt_valid, .rpt, .stall, .rpt_ready, .got, .got_n
  );

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_tests++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic results();
    $display("%0d checks, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [63:0] frm(input logic [7:0] q, b0, b1, b2, b3);
    return {24'h02_067F, q, b3, b2, b1, b0};
  endfunction

  // one-cycle strobes {busy_load, busy_req, media_req, pm_req}
  task automatic fire(input logic [3:0] m);
    {busy_load, busy_req, media_req, pm_req} = m;
    @(negedge core_clk);
    {busy_load, busy_req, media_req, pm_req} = 4'h0;
  endtask

  task automatic take(output esn_pkg::report_t r);
    logic [7:0] n0;
    n0 = got_n;
    for (int k = 0; k < 40 && got_n == n0; k++)
      @(negedge core_clk);
    if (got_n == n0) begin
      bad_count++;
      $display("no report by %0t", $time);
      results();
    end
    r = got;
  endtask

  task automatic t_power();
    esn_pkg::report_t r;
    logic [7:0] ev;
    logic [7:0] ps;
    for (int k = 0; k < 4; k++) begin
      for (int s = 0; s < 4; s++) begin
        pm_kind = esn_pkg::pm_kind_t'(k);
        pm_state = esn_pkg::pwr_state_t'(s);
        fire(4'h1);
        take(r);
        // reserved kind reports no change, reserved state reads as active
        ev = (k == 3) ? 8'h00 : 8'(k);
        ps = (s == 0) ? 8'h01 : 8'(s);
        check(r, frm(8'h02, ev, ps, 8'h00, 8'h00));
      end
    end
    $display("power done");
  endtask

  task automatic t_media();
    esn_pkg::report_t r;
    logic [7:0] st;
    logic [15:0] sl;
    for (int i = 0; i < 16; i++) begin
      media_kind = esn_pkg::media_kind_t'(i[1:0]);
      multi_slot = i[0];
      sense_when_open = i[1];
      door_open_pin = i[2];
      media_present_pin = i[3];
      start_slot = 8'h10 + 8'(i);
      end_slot = 8'hA0 + 8'(i);
      repeat (3) @(negedge core_clk);
      fire(4'h2);
      take(r);
      st = {6'h00, i[3] & (i[1] | ~i[2]), i[2]};
      sl = i[0] ? {end_slot, start_slot} : 16'h0000;
      check(r, frm(8'h04, 8'(i[1:0]), st, sl[7:0], sl[15:8]));
    end
    $display("media done");
  endtask

  task automatic t_busy();
    esn_pkg::report_t r;
    busy_time = 16'h1234;
    for (int i = 0; i < 8; i++) begin
      busy_timeout = i[2];
      busy_reason = esn_pkg::busy_reason_t'(i[1:0]);
      fire(4'hC);
      take(r);
      check(r, frm(8'h06, 8'(i[2]), 8'(i[1:0]), 8'h12, 8'h34));
    end
    busy_time = 16'h0005;
    fire(4'h8);
    check(64'(busy_remaining), 64'h5);
    // one unit of the estimate per four cycles with the short tick
    repeat (3) @(negedge core_clk);
    check(64'(busy_remaining), 64'h5);
    @(negedge core_clk);
    check(64'(busy_remaining), 64'h4);
    // an event without a load reports the live estimate
    fire(4'h4);
    take(r);
    check(r, frm(8'h06, 8'h01, 8'h03, 8'h00, 8'h04));
    repeat (30) @(negedge core_clk);
    check(64'(busy_remaining), 64'h0);
    $display("busy done");
  endtask

  task automatic t_order();
    esn_pkg::report_t r;
    stall = 4'h3;
    fire(4'h7);
    check(64'(pending), 64'h7);
    for (int q = 2; q < 7; q += 2) begin
      take(r);
      check(64'(r.qualifier), 64'(q));
    end
    stall = 4'h0;
    $display("order done");
  endtask

  // a report already offered completes; waiting ones are discarded
  task automatic t_enable();
    logic [7:0] n0;
    n0 = got_n;
    stall = 4'h8;
    fire(4'h7);
    @(negedge core_clk);
    unsol_enable = 1'b0;
    fire(4'h7);
    repeat (16) @(negedge core_clk);
    check(64'(pending), 64'h0);
    check(64'(got_n), 64'(n0 + 8'h01));
    unsol_enable = 1'b1;
    stall = 4'h0;
    $display("enable done");
  endtask

  initial begin
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    check(64'(rpt), 64'h0);
    check(64'({rpt_valid, pending, busy_remaining}), 64'h0);
    t_power();
    t_media();
    t_busy();
    t_order();
    t_enable();
    results();
  end
endmodule // test_event_status_info_encoder
